// [inc/sdram_lp_regs.vh]
// Constants for the SDRAM refresh and low-power controller
`ifndef SDRAM_LP_REGS_VH
`define SDRAM_LP_REGS_VH

// ----------------------------------------
// Memory command codes on cmd_o
// ----------------------------------------
`define CMD_NOP 3'h0
`define CMD_PRECH_ALL 3'h1
`define CMD_AUTO_REF 3'h2
`define CMD_SELF_REF 3'h3
`define CMD_LOAD_EMR 3'h4
`define CMD_DEEP_PD 3'h5

// ----------------------------------------
// Memory types on mem_type_i
// ----------------------------------------
`define MEM_SDR 2'h0
`define MEM_LPSDR 2'h1
`define MEM_LPDDR 2'h2
`define MEM_DDR2 2'h3

// ----------------------------------------
// Low-power command field values
// ----------------------------------------
`define LPC_NONE 2'h0
`define LPC_SELF_REF 2'h1
`define LPC_POWER_DOWN 2'h2
`define LPC_DEEP 2'h3

// ----------------------------------------
// Entry delay field and its counts
// ----------------------------------------
`define TO_NOW 2'h0
`define TO_64 2'h1
`define TO_128 2'h2
`define TO_CNT_64 12'h040
`define TO_CNT_128 12'h080

// ----------------------------------------
// Extended mode register write layout
// ----------------------------------------
`define EMR_BANK 2'h2
`define EMR_ARRAY_LSB 0
`define EMR_DRIVE_LSB 5
`define UPD_SHARED 1'h1

`endif

// [verilog/sdram_lp_down_cnt.v]
// Loadable 12-bit down counter with a zero flag
`timescale 1ns/1ps
module sdram_lp_down_cnt (
  input wire clk_i, // Controller clock
  input wire rst_b_i, // Synchronous reset, active low
  input wire load_i, // Load val_i this cycle
  input wire [11:0] val_i, // Count to load
  output wire zero_o // Counter has reached zero
);

  reg [11:0] cnt_reg; // Remaining cycles
  reg [11:0] cnt_next; // Next count

  // ----------------------------------------
  // Next count: load wins, else step down to zero
  // ----------------------------------------
  always @* begin
    if (load_i) begin
      cnt_next = val_i;
    end else if (cnt_reg != 12'h000) begin
      cnt_next = cnt_reg - 12'h001;
    end else begin
      cnt_next = cnt_reg;
    end
  end

  // Counter flop, cleared at reset
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt_reg <= 12'h000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign zero_o = (cnt_reg == 12'h000);

endmodule

// [verilog/sdram_lp_emr_watch.v]
// Watches the partial-array and drive-strength fields for changes
`timescale 1ns/1ps
module sdram_lp_emr_watch (
  input wire clk_i, // Controller clock
  input wire rst_b_i, // Synchronous reset, active low
  input wire init_done_i, // Memory initialisation finished
  input wire [2:0] arr_i, // Partial array refresh select
  input wire [1:0] drv_i, // Drive strength select
  input wire done_i, // Extended mode register written
  output reg pend_o // Update owed to the memory
);

  reg [4:0] shadow_reg; // Fields last seen

  // ----------------------------------------
  // Change detection, the change beats the clear
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      shadow_reg <= 5'h00;
      pend_o <= 1'b0;
    end else if (!init_done_i) begin
      // Initialisation itself programs the memory
      shadow_reg <= {arr_i, drv_i};
      pend_o <= 1'b0;
    end else begin
      shadow_reg <= {arr_i, drv_i};
      pend_o <= (shadow_reg != {arr_i, drv_i}) | (pend_o & ~done_i);
    end
  end

endmodule

// [verilog/sdram_refresh_low_power_ctrl.v]
// Refresh, self refresh, power-down and freeze control for the SDRAM controller
//
// Behaviour
// - Periodic auto-refresh from interval counter
// - Busy to masters while refresh runs
// - Refresh never breaks a running burst
// - Command 1: self refresh when idle
// - CKE held low in self refresh
// - Exit on access, re-enter when deselected
// - Self refresh entry delay 0/64/128
// - Precharge all, then self refresh command
// - Access in between: auto-refresh instead
// - Changed array or strength fields rewrite mode register
// - Update type picks when register written
// - Minimum self refresh residency per type
// - No 4K refresh burst around self refresh
// - Command 2: power-down, CKE low, buffers off
// - Controller keeps refreshing during power-down
// - Power-down exit by NOP, tXP for LPDDR
// - LPDDR/DDR2 hold power-down at least tCKE
// - Power-down entry delay 0/64/128
// - Command 3: deep power-down, then freeze
// - Command 3 with freeze: reset mode
`timescale 1ns/1ps
`include "sdram_lp_regs.vh"
module sdram_refresh_low_power_ctrl (
  input wire clk_i, // Controller clock, 125 MHz
  input wire rst_b_i, // Synchronous reset, active low
  input wire [11:0] refresh_interval_i, // Cycles between refreshes, 0 stops
  input wire [1:0] low_power_command_i, // Low-power command field
  input wire clock_freeze_bit_i, // Selects reset mode with command 3
  input wire [1:0] timeout_sel_i, // Low-power entry delay field
  input wire ext_mode_update_type_i, // 1 = shared external bus
  input wire [2:0] partial_array_refresh_sel_i, // Partial array refresh field
  input wire [1:0] drive_strength_sel_i, // Drive strength field
  input wire [1:0] mem_type_i, // Memory type
  input wire init_done_i, // Initialisation complete
  input wire acc_req_i, // A master selects the memory
  input wire burst_active_i, // Burst transfer in progress
  input wire [7:0] t_rp_i, // Precharge time, cycles
  input wire [7:0] t_rfc_i, // Refresh cycle time, cycles
  input wire [7:0] t_ras_i, // Active time, cycles
  input wire [7:0] t_cke_i, // CKE minimum pulse, cycles
  input wire [7:0] t_xp_i, // Power-down exit time, cycles
  input wire [7:0] t_mrd_i, // Mode register set time, cycles
  output reg busy_o, // Stall bus masters
  output reg [2:0] cmd_o, // Memory command this cycle
  output reg cke_o, // Clock enable pin
  output reg io_buf_en_o, // Memory pad buffers enabled
  output reg [1:0] ba_o, // Bank address with command
  output reg [12:0] addr_o, // Address with command
  output reg normal_mode_o, // Controller in normal mode
  output reg frozen_o // Controller frozen
);

  // ----------------------------------------
  // States, one-hot
  // ----------------------------------------
  localparam [9:0] ST_IDLE = 10'h001; // Normal operation
  localparam [9:0] ST_PRE_W = 10'h002; // Waiting tRP after precharge all
  localparam [9:0] ST_REF_W = 10'h004; // Waiting tRFC after auto-refresh
  localparam [9:0] ST_EMR_W = 10'h008; // Waiting tMRD after mode write
  localparam [9:0] ST_SR = 10'h010; // In self refresh
  localparam [9:0] ST_SR_X = 10'h020; // Self refresh exit wait
  localparam [9:0] ST_PD = 10'h040; // In power-down
  localparam [9:0] ST_PD_X = 10'h080; // Power-down exit wait
  localparam [9:0] ST_FROZEN = 10'h100; // Deep power-down or reset mode

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Widen an 8-bit timing to timer width
  function [11:0] widen(input [7:0] t);
    widen = {4'h0, t};
  endfunction
  // True for the types that need a tCKE hold in power-down
  function ddr_type(input [1:0] mt);
    ddr_type = (mt == `MEM_LPDDR) || (mt == `MEM_DDR2);
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [9:0] state_reg; // Current state
  reg [9:0] state_next; // Next state
  reg ref_pend_reg; // Refresh owed
  reg sr_entry_reg, sr_entry_next; // Precharge belongs to self refresh entry
  reg acc_seen_reg, acc_seen_next; // Access seen during the precharge window
  reg emr_to_sr_reg, emr_to_sr_next; // Mode write leads into self refresh
  reg busy_next, cke_next, iobuf_next, normal_next, frozen_next; // Next output levels
  reg [2:0] cmd_next; // Next command
  reg [1:0] ba_next; // Next bank address
  reg [12:0] addr_next; // Next address
  reg ph_load, ref_clr, emr_done; // Timer load, refresh issued, mode written
  reg go_emr, go_sr; // Start a mode write or self refresh
  reg [11:0] ph_val; // Phase timer count

  wire ref_zero, idle_zero, ph_zero; // Timer flags
  wire acc_active, lp_ok, ref_expire, ref_off; // In use, entry allowed, refresh due, off
  wire emr_pend, ref_pend_next; // Mode write owed, next refresh owed
  wire [11:0] idle_val; // Entry delay count
  wire [11:0] sr_res; // Self refresh residency for the type
  wire [12:0] emr_word; // Extended mode register value

  assign acc_active = acc_req_i | burst_active_i;
  // Interval 0 parks the timer at zero so a new interval starts at once
  assign ref_off = (refresh_interval_i == 12'h000);
  assign ref_expire = ref_zero & !ref_off;
  // set wins over clear, request never lost
  assign ref_pend_next = ref_expire | (ref_pend_reg & ~ref_clr);
  assign idle_val = (timeout_sel_i == `TO_128) ? `TO_CNT_128 : `TO_CNT_64;
  assign lp_ok = !acc_active && ((timeout_sel_i == `TO_NOW) || idle_zero);
  assign emr_word = ({10'h000, partial_array_refresh_sel_i} << `EMR_ARRAY_LSB) |
                    ({11'h000, drive_strength_sel_i} << `EMR_DRIVE_LSB);
  // tRAS, tRFC or tCKE by type
  assign sr_res = (mem_type_i == `MEM_LPDDR) ? widen(t_rfc_i) :
                  (mem_type_i == `MEM_DDR2) ? widen(t_cke_i) : widen(t_ras_i);

  // ----------------------------------------
  // Timers
  // ----------------------------------------
  // timer reloads itself on every expiry
  sdram_lp_down_cnt u_ref_tmr (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .load_i(ref_zero | ref_off),
    .val_i(ref_off ? 12'h000 : refresh_interval_i - 12'h001), .zero_o(ref_zero)
  );
  // Entry delay restarts while the memory is in use
  sdram_lp_down_cnt u_idle_tmr (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .load_i(acc_active), .val_i(idle_val),
    .zero_o(idle_zero)
  );
  // Command spacing and residency waits
  sdram_lp_down_cnt u_ph_tmr (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .load_i(ph_load), .val_i(ph_val),
    .zero_o(ph_zero)
  );
  sdram_lp_emr_watch u_emr_watch (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .init_done_i(init_done_i),
    .arr_i(partial_array_refresh_sel_i), .drv_i(drive_strength_sel_i),
    .done_i(emr_done), .pend_o(emr_pend)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Outputs are computed here and registered below
  always @* begin
    state_next = state_reg;
    sr_entry_next = sr_entry_reg;
    acc_seen_next = acc_seen_reg;
    emr_to_sr_next = emr_to_sr_reg;
    cmd_next = `CMD_NOP;
    cke_next = cke_o;
    iobuf_next = io_buf_en_o;
    ba_next = 2'h0;
    addr_next = 13'h0000;
    normal_next = normal_mode_o;
    frozen_next = frozen_o;
    ph_load = 1'b0;
    ph_val = 12'h000;
    ref_clr = 1'b0;
    emr_done = 1'b0;
    go_emr = 1'b0;
    go_sr = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        cke_next = 1'b1;
        iobuf_next = 1'b1;
        normal_next = 1'b1;
        if (low_power_command_i == `LPC_DEEP && !acc_active) begin
          cmd_next = clock_freeze_bit_i ? `CMD_NOP : `CMD_DEEP_PD;
          cke_next = 1'b0;
          normal_next = 1'b0;
          frozen_next = 1'b1;
          state_next = ST_FROZEN;
        // refresh waits for the burst to end
        end else if ((ref_pend_reg && !burst_active_i) ||
            (low_power_command_i == `LPC_SELF_REF && lp_ok)) begin
          cmd_next = `CMD_PRECH_ALL;
          // An owed refresh outranks self refresh entry
          sr_entry_next = !ref_pend_reg;
          acc_seen_next = 1'b0;
          ph_load = 1'b1;
          ph_val = widen(t_rp_i);
          state_next = ST_PRE_W;
        end else if (low_power_command_i == `LPC_POWER_DOWN && lp_ok) begin
          cke_next = 1'b0;
          iobuf_next = 1'b0;
          ph_load = 1'b1;
          // tCKE hold for LPDDR and DDR2
          ph_val = ddr_type(mem_type_i) ? widen(t_cke_i) : 12'h000;
          state_next = ST_PD;
        end
      end
      ST_PRE_W: begin
        // remember any access in the window
        acc_seen_next = acc_seen_reg | acc_req_i;
        if (ph_zero) begin
          if (sr_entry_reg && !acc_seen_reg && !acc_req_i) begin
            // no shared bus: update before entry
            go_emr = emr_pend && ext_mode_update_type_i != `UPD_SHARED;
            emr_to_sr_next = 1'b1;
            // straight in, no refresh burst first
            go_sr = !go_emr;
          end else begin
            cmd_next = `CMD_AUTO_REF;
            ref_clr = 1'b1;
            ph_load = 1'b1;
            ph_val = widen(t_rfc_i);
            state_next = ST_REF_W;
          end
        end
      end
      ST_REF_W: begin
        if (ph_zero) begin
          // shared bus: update with refresh and access
          go_emr = emr_pend && ext_mode_update_type_i == `UPD_SHARED && acc_req_i;
          emr_to_sr_next = 1'b0;
          state_next = ST_IDLE;
        end
      end
      ST_EMR_W: begin
        if (ph_zero) begin
          go_sr = emr_to_sr_reg && !acc_req_i;
          state_next = ST_IDLE;
        end
      end
      ST_SR: begin
        // CKE stays low, memory refreshes itself
        cke_next = 1'b0;
        ref_clr = ref_pend_reg;
        // exit on access once residency is met
        if (ph_zero && (acc_req_i || low_power_command_i != `LPC_SELF_REF)) begin
          cke_next = 1'b1;
          ph_load = 1'b1;
          ph_val = widen(t_rfc_i);
          state_next = ST_SR_X;
        end
      end
      // NOPs with CKE high until the memory accepts commands
      ST_SR_X, ST_PD_X: begin
        if (ph_zero) begin
          state_next = ST_IDLE;
        end
      end
      ST_PD: begin
        cke_next = 1'b0;
        iobuf_next = 1'b0;
        // wake up to refresh the memory ourselves
        if (ph_zero && (acc_req_i || ref_pend_reg || low_power_command_i != `LPC_POWER_DOWN)) begin
          cke_next = 1'b1;
          iobuf_next = 1'b1;
          ph_load = 1'b1;
          ph_val = (mem_type_i == `MEM_LPDDR) ? widen(t_xp_i) : 12'h000;
          state_next = ST_PD_X;
        end
      end
      ST_FROZEN: begin
        cke_next = 1'b0;
        if (low_power_command_i == `LPC_NONE && !clock_freeze_bit_i) begin
          frozen_next = 1'b0;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // mode write carries the new field values
    if (go_emr) begin
      cmd_next = `CMD_LOAD_EMR;
      ba_next = `EMR_BANK;
      addr_next = emr_word;
      emr_done = 1'b1;
      ph_load = 1'b1;
      ph_val = widen(t_mrd_i);
      state_next = ST_EMR_W;
    end
    // self refresh command goes out with CKE low
    if (go_sr) begin
      cmd_next = `CMD_SELF_REF;
      cke_next = 1'b0;
      ref_clr = ref_pend_reg;
      ph_load = 1'b1;
      ph_val = sr_res;
      state_next = ST_SR;
    end
    // masters stall whenever the sequencer is away from idle
    busy_next = (state_next != ST_IDLE);
  end

  // ----------------------------------------
  // State and output flops
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_IDLE;
      ref_pend_reg <= 1'b0;
      sr_entry_reg <= 1'b0;
      acc_seen_reg <= 1'b0;
      emr_to_sr_reg <= 1'b0;
      busy_o <= 1'b0;
      cmd_o <= `CMD_NOP;
      cke_o <= 1'b1;
      io_buf_en_o <= 1'b1;
      ba_o <= 2'h0;
      addr_o <= 13'h0000;
      normal_mode_o <= 1'b1;
      frozen_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      ref_pend_reg <= ref_pend_next;
      sr_entry_reg <= sr_entry_next;
      acc_seen_reg <= acc_seen_next;
      emr_to_sr_reg <= emr_to_sr_next;
      busy_o <= busy_next;
      cmd_o <= cmd_next;
      cke_o <= cke_next;
      io_buf_en_o <= iobuf_next;
      ba_o <= ba_next;
      addr_o <= addr_next;
      normal_mode_o <= normal_next;
      frozen_o <= frozen_next;
    end
  end

endmodule

// [dv/sdram_mem_model.sv]
// Behavioural SDRAM device seen from the controller's command pins
`timescale 1ns/1ps
`include "sdram_lp_regs.vh"
module sdram_mem_model (
  input wire clk_i, // Controller clock
  input wire rst_b_i, // Reset, active low
  input wire [2:0] cmd_i, // Command taken at each edge
  input wire cke_i, // Clock enable pin
  output reg [7:0] n_ref_o, // Auto-refresh commands taken
  output reg in_sr_o // Device refreshing itself
);
  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  // Self refresh only sticks when CKE is already low with the command
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      n_ref_o <= 8'h00;
      in_sr_o <= 1'b0;
    end else begin
      if (cmd_i == `CMD_AUTO_REF) n_ref_o <= n_ref_o + 8'h01;
      if (cmd_i == `CMD_SELF_REF && !cke_i) in_sr_o <= 1'b1;
      else if (cke_i) in_sr_o <= 1'b0;
    end
  end
endmodule

// [dv/sdram_refresh_low_power_ctrl_assertions.sv]
// Concurrent checks on the ports of the refresh and low-power controller
`timescale 1ns/1ps
`include "sdram_lp_regs.vh"
module sdram_lp_ctrl_checker (
  input wire clk_i, // Controller clock
  input wire rst_b_i, // Reset, active low
  input wire [1:0] low_power_command_i, // Low-power command
  input wire clock_freeze_bit_i, // Freeze bit
  input wire [2:0] partial_array_refresh_sel_i, // Partial array field
  input wire [1:0] drive_strength_sel_i, // Drive strength field
  input wire [1:0] mem_type_i, // Memory type
  input wire burst_active_i, // Burst running
  input wire [7:0] t_rfc_i, // Refresh cycle time
  input wire [7:0] t_ras_i, // Active time
  input wire [7:0] t_cke_i, // CKE minimum
  input wire busy_o, // Stall
  input wire [2:0] cmd_o, // Command
  input wire cke_o, // Clock enable
  input wire io_buf_en_o, // Pad buffers
  input wire [1:0] ba_o, // Bank address
  input wire [12:0] addr_o, // Address
  input wire normal_mode_o, // Normal mode
  input wire frozen_o // Frozen
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // ----------------------------------------
  // Self refresh residency tracking
  // ----------------------------------------
  reg in_sr_reg; // Between self refresh command and CKE rise
  reg [7:0] sr_cnt_reg; // Cycles since self refresh command
  wire [7:0] sr_min = (mem_type_i == `MEM_LPDDR) ? t_rfc_i :
    (mem_type_i == `MEM_DDR2) ? t_cke_i : t_ras_i; // Minimum stay
  // Saturates so that a long stay never wraps under the minimum
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      in_sr_reg <= 1'b0;
      sr_cnt_reg <= 8'h00;
    end else if (cmd_o == `CMD_SELF_REF) begin
      in_sr_reg <= 1'b1;
      sr_cnt_reg <= 8'h01;
    end else begin
      if (cke_o) in_sr_reg <= 1'b0;
      if (sr_cnt_reg != 8'hff) sr_cnt_reg <= sr_cnt_reg + 8'h01;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // CKE low
  sr_cke_low_a: assert property (cmd_o == `CMD_SELF_REF |-> !cke_o)
    else $error("CKE high with self refresh command");
  sr_residency_a: assert property (in_sr_reg && cke_o |-> sr_cnt_reg >= sr_min)
    else $error("self refresh left too early");
  prech_follow_a: assert property (cmd_o == `CMD_PRECH_ALL |=> cmd_o == `CMD_NOP ##[1:40]
    (cmd_o == `CMD_AUTO_REF || cmd_o == `CMD_SELF_REF || cmd_o == `CMD_LOAD_EMR))
    else $error("precharge not followed by refresh command");
  refresh_busy_a: assert property (cmd_o == `CMD_AUTO_REF |-> busy_o)
    else $error("refresh without busy");
  burst_hold_a: assert property (cmd_o == `CMD_PRECH_ALL |-> !$past(burst_active_i))
    else $error("precharge during burst");
  deep_freeze_a: assert property (cmd_o == `CMD_DEEP_PD |->
    frozen_o && !normal_mode_o && !cke_o)
    else $error("deep power-down without freeze");
  freeze_cause_a: assert property ($rose(frozen_o) |->
    $past(low_power_command_i) == `LPC_DEEP)
    else $error("freeze without command 3");
  reset_mode_a: assert property ($rose(frozen_o) && $past(clock_freeze_bit_i) |->
    cmd_o != `CMD_DEEP_PD && !cke_o)
    else $error("reset mode entry wrong");
  frozen_quiet_a: assert property (frozen_o && $past(frozen_o) |-> cmd_o == `CMD_NOP)
    else $error("command while frozen");
  pd_cke_a: assert property (!io_buf_en_o |-> !cke_o)
    else $error("buffers off with CKE high");
  emr_word_a: assert property (cmd_o == `CMD_LOAD_EMR |-> ba_o == `EMR_BANK && addr_o ==
    {6'h00, drive_strength_sel_i, 2'h0, partial_array_refresh_sel_i})
    else $error("extended mode word wrong");
endmodule
bind sdram_refresh_low_power_ctrl sdram_lp_ctrl_checker chk_u (.clk_i(clk_i),
  .rst_b_i(rst_b_i), .low_power_command_i(low_power_command_i),
  .clock_freeze_bit_i(clock_freeze_bit_i),
  .partial_array_refresh_sel_i(partial_array_refresh_sel_i),
  .drive_strength_sel_i(drive_strength_sel_i), .mem_type_i(mem_type_i),
  .burst_active_i(burst_active_i), .t_rfc_i(t_rfc_i), .t_ras_i(t_ras_i),
  .t_cke_i(t_cke_i), .busy_o(busy_o), .cmd_o(cmd_o), .cke_o(cke_o),
  .io_buf_en_o(io_buf_en_o), .ba_o(ba_o), .addr_o(addr_o),
  .normal_mode_o(normal_mode_o), .frozen_o(frozen_o));

// [dv/sdram_refresh_low_power_ctrl_bench.sv]
// Self-checking bench for the SDRAM refresh and low-power controller
`timescale 1ns/1ps
`include "sdram_lp_regs.vh"
module sdram_refresh_low_power_ctrl_bench;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  reg clk_i = 1'b0; // 125 MHz clock
  reg rst_b_i = 1'b0; // Reset, active low
  reg [11:0] interval = 12'h000; // Refresh interval, 0 stops
  reg [1:0] lpc = `LPC_NONE; // Low-power command
  reg frz = 1'b0; // Freeze bit
  reg [1:0] tsel = `TO_NOW; // Entry delay
  reg upd = 1'b0; // Update type
  reg [2:0] arr = 3'h0; // Partial array field
  reg [1:0] drv = 2'h0; // Drive strength field
  reg [1:0] mt = `MEM_LPSDR; // Memory type
  reg init_done = 1'b1; // Software init finished
  reg acc = 1'b0; // Master selects memory
  reg burst = 1'b0; // Burst running
  reg [7:0] t_rp = 8'h02, t_rfc = 8'h03, t_ras = 8'h04; // Short timings keep runs brief
  reg [7:0] t_cke = 8'h03, t_xp = 8'h02, t_mrd = 8'h02; // Short timings
  wire busy, cke, iob, nrm, frozen, in_sr; // Controller and memory status
  wire [2:0] cmd; // Command
  wire [1:0] ba; // Bank address
  wire [12:0] addr; // Address
  wire [7:0] n_ref; // Refreshes seen by memory
  integer n_mismatch = 0; // Mismatches
  integer comparisons = 0; // Comparisons
  sdram_refresh_low_power_ctrl dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .refresh_interval_i(interval), .low_power_command_i(lpc), .clock_freeze_bit_i(frz),
    .timeout_sel_i(tsel), .ext_mode_update_type_i(upd), .partial_array_refresh_sel_i(arr),
    .drive_strength_sel_i(drv), .mem_type_i(mt), .init_done_i(init_done), .acc_req_i(acc),
    .burst_active_i(burst), .t_rp_i(t_rp), .t_rfc_i(t_rfc), .t_ras_i(t_ras),
    .t_cke_i(t_cke), .t_xp_i(t_xp), .t_mrd_i(t_mrd), .busy_o(busy), .cmd_o(cmd),
    .cke_o(cke), .io_buf_en_o(iob), .ba_o(ba), .addr_o(addr), .normal_mode_o(nrm),
    .frozen_o(frozen));
  sdram_mem_model mem_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .cmd_i(cmd), .cke_i(cke),
    .n_ref_o(n_ref), .in_sr_o(in_sr));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  initial forever #4 clk_i = ~clk_i;
  task check(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        n_mismatch = n_mismatch + 1;
      end
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(negedge clk_i);
  endtask
  // Bounded wait; the caller judges the count that comes back
  task wait_cmd(input [2:0] code, input integer lim, output integer n);
    begin
      n = 0;
      while (cmd !== code && n < lim) begin
        @(negedge clk_i);
        n = n + 1;
      end
    end
  endtask
  task finish_test;
    begin
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
        $display("Result: passed");
      end else begin
        $display("Result: failed");
      end
      $finish;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task test_refresh;
    integer n;
    reg [7:0] r;
    begin
      interval = 12'h028;
      wait_cmd(`CMD_AUTO_REF, 100, n);
      check(busy, 1'b1);
      cyc(1);
      wait_cmd(`CMD_AUTO_REF, 100, n);
      check(n + 1, 32'h28);
      burst = 1'b1;
      cyc(1);
      r = n_ref;
      cyc(100);
      check(n_ref, r);
      burst = 1'b0;
      wait_cmd(`CMD_PRECH_ALL, 3, n);
      check(n < 3, 1'b1);
      interval = 12'h000;
      cyc(20);
      $display("test_refresh done");
    end
  endtask
  task test_self_ref;
    integer n;
    reg [7:0] r;
    begin
      r = n_ref;
      lpc = `LPC_SELF_REF;
      wait_cmd(`CMD_PRECH_ALL, 10, n);
      wait_cmd(`CMD_SELF_REF, 10, n);
      cyc(1);
      check({cke, in_sr}, 2'b01);
      acc = 1'b1;
      n = 1;
      while (cke !== 1'b1 && n < 40) begin
        @(negedge clk_i);
        n = n + 1;
      end
      check(n >= 4 && n < 40, 1'b1);
      cyc(10);
      check(n_ref, r);
      acc = 1'b0;
      wait_cmd(`CMD_PRECH_ALL, 10, n);
      acc = 1'b1;
      wait_cmd(`CMD_AUTO_REF, 8, n);
      check({n < 8, in_sr}, 2'b10);
      lpc = `LPC_NONE;
      cyc(10);
      $display("test_self_ref done");
    end
  endtask
  task test_timeout;
    integer n, i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        lpc = (i < 2) ? `LPC_SELF_REF : `LPC_POWER_DOWN;
        tsel = i[0] ? `TO_128 : `TO_64;
        cyc(2);
        acc = 1'b0;
        n = 0;
        while (cmd !== `CMD_PRECH_ALL && iob === 1'b1 && n < 200) begin
          @(negedge clk_i);
          n = n + 1;
        end
        check(n >= (i[0] ? 128 : 64) && n <= (i[0] ? 132 : 68), 1'b1);
        acc = 1'b1;
        cyc(40);
      end
      lpc = `LPC_NONE;
      tsel = `TO_NOW;
      $display("test_timeout done");
    end
  endtask
  task test_emr;
    integer n;
    begin
      arr = 3'h5;
      drv = 2'h2;
      lpc = `LPC_SELF_REF;
      cyc(2);
      acc = 1'b0;
      wait_cmd(`CMD_PRECH_ALL, 10, n);
      wait_cmd(`CMD_LOAD_EMR, 10, n);
      check({n < 10, ba, addr}, {1'b1, `EMR_BANK, 6'h00, drv, 2'h0, arr});
      wait_cmd(`CMD_SELF_REF, 10, n);
      check(n < 10, 1'b1);
      acc = 1'b1;
      lpc = `LPC_NONE;
      cyc(30);
      // Shared bus: the write rides on a refresh with an access waiting
      upd = `UPD_SHARED;
      arr = 3'h2;
      interval = 12'h01e;
      wait_cmd(`CMD_LOAD_EMR, 80, n);
      check({n < 80, ba, addr}, {1'b1, `EMR_BANK, 6'h00, drv, 2'h0, arr});
      interval = 12'h000;
      upd = 1'b0;
      cyc(20);
      $display("test_emr done");
    end
  endtask
  task test_power_down;
    integer n;
    reg [7:0] r;
    begin
      mt = `MEM_LPDDR;
      lpc = `LPC_POWER_DOWN;
      cyc(2);
      acc = 1'b0;
      n = 0;
      while (iob !== 1'b0 && n < 10) begin
        @(negedge clk_i);
        n = n + 1;
      end
      check({iob, cke}, 2'b00);
      acc = 1'b1;
      n = 0;
      while (cke !== 1'b1 && n < 20) begin
        @(negedge clk_i);
        n = n + 1;
      end
      check(n >= 3 && n < 20, 1'b1);
      repeat (2) begin
        check(cmd, `CMD_NOP);
        cyc(1);
      end
      r = n_ref;
      acc = 1'b0;
      interval = 12'h032;
      cyc(150);
      check(n_ref - r >= 8'h02, 1'b1);
      interval = 12'h000;
      lpc = `LPC_NONE;
      acc = 1'b1;
      mt = `MEM_LPSDR;
      cyc(20);
      $display("test_power_down done");
    end
  endtask
  task test_deep;
    integer n;
    begin
      acc = 1'b0;
      lpc = `LPC_DEEP;
      wait_cmd(`CMD_DEEP_PD, 5, n);
      check({n < 5, frozen, nrm}, 3'b110);
      lpc = `LPC_SELF_REF;
      cyc(20);
      check({cmd, frozen}, {`CMD_NOP, 1'b1});
      lpc = `LPC_NONE;
      cyc(3);
      check({frozen, nrm}, 2'b01);
      mt = `MEM_DDR2;
      frz = 1'b1;
      lpc = `LPC_DEEP;
      cyc(3);
      check({frozen, nrm, cke}, 3'b100);
      lpc = `LPC_NONE;
      cyc(3);
      check(frozen, 1'b1);
      frz = 1'b0;
      cyc(3);
      check({frozen, nrm}, 2'b01);
      $display("test_deep done");
    end
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    rst_b_i = 1'b1;
    cyc(1);
    test_refresh;
    test_self_ref;
    test_timeout;
    test_emr;
    test_power_down;
    test_deep;
    finish_test;
  end
  // Roughly five times the expected run length
  initial begin
    #40000;
    n_mismatch = n_mismatch + 1;
    finish_test;
  end
endmodule
